// >>> vab_pkg.sv
/*
 vab_pkg: constants, field layouts and types for the auxiliary line code
 buffer. Assumes nothing beyond a SystemVerilog compiler.
*/
package vab_pkg;
	localparam int CODE_BITS = 77;
	localparam int LEAD_BITS = 10;
	localparam int CRC_W = 16;
	localparam int FIELD_W = 18;
	localparam int BAND_W = 6;
	localparam int AUX_W = 27;
	localparam int WORD_W = FIELD_W + BAND_W + AUX_W;
	localparam int CODE_LINE = 17;
	localparam int LINE_W = 9;
	localparam int BIT_W = 7;
	localparam logic [LINE_W-1:0] CODE_LINE_M1 = LINE_W'(CODE_LINE - 1);
	localparam logic [LINE_W-1:0] CODE_LINE_V = LINE_W'(CODE_LINE);
	localparam logic [LINE_W-1:0] LINE_MAX = 9'h1ff;
	localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(CODE_BITS - 1);
	localparam logic [BIT_W-1:0] LEAD_IDX = BIT_W'(LEAD_BITS);
	localparam logic [CRC_W-1:0] CRC_POLY = 16'h1021;
	localparam logic [CRC_W-1:0] CRC_INIT = 16'h0000;
	localparam int SUBCARRIER_KHZ = 1530;
	localparam int CLK_MHZ = 200;
	localparam int STATUS_MAX_NS = 1000;
	localparam int STATUS_MAX_CYC = STATUS_MAX_NS * CLK_MHZ / 1000;
	localparam int FIFO_DEPTH = 2;
	localparam logic [1:0] FIFO_FULL = 2'h2;

	typedef struct packed {
		logic [FIELD_W-1:0] field;
		logic [BAND_W-1:0] band;
		logic [AUX_W-1:0] aux;
	} vab_word_s;

	typedef struct packed {
		logic ok;
		vab_word_s word;
	} vab_entry_s;

	typedef enum logic [1:0] {
		VAB_WAIT = 2'h0,
		VAB_SHIFT = 2'h1,
		VAB_CHECK = 2'h3,
		VAB_SEND = 2'h2
	} vab_state_e;
endpackage

// >>> vab_aux_code_buffer.sv
/*
 vab_aux_code_buffer: captures the auxiliary code of one video line per
 field on the squared subcarrier clock, checks it, and offers it to a
 host that reads it out serially with its own slow shift clock.
 Assumes the analog front end delivers the squared subcarrier as a clock
 and sliced video, line and field pulses aligned to that clock.
*/
// Notes on behaviour
// - capture logic runs on the squared 1.53 MHz subcarrier clock
// - each field, 77 code bits are shifted in on that clock
// - only video line 17 of each field is decoded
// - with request high, status goes high when a good code is held
// - stored bits leave on data out, one per host clock pulse while request is low
// - payload holds an 18-bit field number and 6-bit band number
// - 27 spare code bits follow the payload for the host
// - status updates within 1 us of request going low
// - output shifter runs on host clock whether check passed or not
`timescale 1ns/1ps
module vab_aux_code_buffer (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic sub_clk_i,
	input wire logic field_sync_i,
	input wire logic line_sync_i,
	input wire logic video_bit_i,
	input wire logic ctrl_i,
	input wire logic host_clk_i,
	output logic status_o,
	output logic data_o
);
	import vab_pkg::*;

	function automatic logic [CRC_W-1:0] crc_step(
		input logic [CRC_W-1:0] c,
		input logic b
	);
		logic fb;
		fb = c[CRC_W-1] ^ b;
		crc_step = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
	endfunction

	// link domain, clocked by the squared subcarrier
	logic [1:0] lrst_sync;
	logic [2:0] pin_s1, pin_s2;
	logic lrst, field_d, line_d, field_rise, line_rise, start;
	logic [LINE_W-1:0] line_cnt;
	vab_state_e state;
	logic [BIT_W-1:0] bit_cnt;
	logic [CODE_BITS-1:0] code_sreg;
	logic [CRC_W-1:0] crc_reg;
	vab_entry_s xfer_reg;
	logic ok_reg, req_tgl, ack_tgl, ack_s1, ack_s2, busy;

	// reset release retimed so link flops leave reset on their own edge
	always_ff @(posedge sub_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lrst_sync <= 2'h3;
		end else begin
			lrst_sync <= {lrst_sync[0], 1'b0};
		end
	end
	assign lrst = lrst_sync[1];

	always_ff @(posedge sub_clk_i or posedge lrst) begin
		if (lrst) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			field_d <= 1'b0;
			line_d <= 1'b0;
		end else begin
			pin_s1 <= {field_sync_i, line_sync_i, video_bit_i};
			pin_s2 <= pin_s1;
			field_d <= pin_s2[2];
			line_d <= pin_s2[1];
		end
	end
	assign field_rise = pin_s2[2] & ~field_d;
	assign line_rise = pin_s2[1] & ~line_d;
	assign start = line_rise & ~field_rise & (line_cnt == CODE_LINE_M1);

	always_ff @(posedge sub_clk_i or posedge lrst) begin
		if (lrst) begin
			line_cnt <= '0;
		end else if (field_rise) begin
			line_cnt <= '0;
		end else if (line_rise && line_cnt != LINE_MAX) begin
			line_cnt <= line_cnt + 1'b1;
		end
	end

	// a code that arrives while the last one still waits in VAB_SEND for busy to clear is lost
	always_ff @(posedge sub_clk_i or posedge lrst) begin
		if (lrst) begin
			state <= VAB_WAIT;
		end else begin
			case (state)
				VAB_WAIT: begin
					if (start && state == VAB_WAIT) begin
						state <= VAB_SHIFT;
					end
				end
				VAB_SHIFT: begin
					if (bit_cnt == LAST_BIT) begin
						state <= VAB_CHECK;
					end
				end
				VAB_CHECK: begin
					state <= VAB_SEND;
				end
				VAB_SEND: begin
					if (!busy) begin
						state <= VAB_WAIT;
					end
				end
				default: begin
					state <= VAB_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge sub_clk_i or posedge lrst) begin
		if (lrst) begin
			bit_cnt <= '0;
			code_sreg <= '0;
			crc_reg <= CRC_INIT;
			ok_reg <= 1'b0;
		end else if (state == VAB_WAIT) begin
			bit_cnt <= '0;
			crc_reg <= CRC_INIT;
		end else if (state == VAB_SHIFT) begin
			code_sreg <= {code_sreg[CODE_BITS-2:0], pin_s2[0]};
			bit_cnt <= bit_cnt + 1'b1;
			if (bit_cnt >= LEAD_IDX) begin
				crc_reg <= crc_step(crc_reg, pin_s2[0]);
			end
		end else if (state == VAB_CHECK) begin
			// check bits ride behind the data, so a good code leaves zero
			ok_reg <= (crc_reg == CRC_INIT);
		end
	end

	always_ff @(posedge sub_clk_i or posedge lrst) begin
		if (lrst) begin
			xfer_reg <= '0;
			req_tgl <= 1'b0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= ack_tgl;
			ack_s2 <= ack_s1;
			if (state == VAB_SEND && !busy) begin
				xfer_reg <= {ok_reg, code_sreg[CRC_W +: WORD_W]};
				req_tgl <= ~req_tgl;
			end
		end
	end
	assign busy = req_tgl ^ ack_s2;

	// system domain
	logic req_s1, req_s2, ctrl_s1, ctrl_s2, hc_s1, hc_s2, hc_d, hclk_rise;
	logic new_word, push, pop, full, empty, wr_ptr, rd_ptr, hold_valid;
	logic status_reg, data_reg;
	logic [1:0] count;
	vab_entry_s fifo_mem [FIFO_DEPTH];
	vab_entry_s head, hold_reg;
	logic [WORD_W-1:0] head_word, out_sreg;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			ctrl_s1 <= 1'b0;
			ctrl_s2 <= 1'b0;
			hc_s1 <= 1'b0;
			hc_s2 <= 1'b0;
			hc_d <= 1'b0;
		end else begin
			req_s1 <= req_tgl;
			req_s2 <= req_s1;
			ctrl_s1 <= ctrl_i;
			ctrl_s2 <= ctrl_s1;
			hc_s1 <= host_clk_i;
			hc_s2 <= hc_s1;
			hc_d <= hc_s2;
		end
	end
	assign hclk_rise = hc_s2 & ~hc_d;

	// xfer_reg is held still by the link side until the ack returns
	assign new_word = req_s2 ^ ack_tgl;
	assign full = (count == FIFO_FULL);
	assign empty = (count == 2'h0);
	assign push = new_word & ~full;
	assign pop = ctrl_s2 & ~empty;
	assign head = fifo_mem[rd_ptr];
	assign head_word = head.word;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ack_tgl <= 1'b0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
			fifo_mem <= '{default: '0};
		end else begin
			if (push) begin
				fifo_mem[wr_ptr] <= xfer_reg;
				wr_ptr <= ~wr_ptr;
				ack_tgl <= ~ack_tgl;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	// the buffer drains only while the host requests, so a slow read
	// stalls it and, through the withheld ack, the capture side
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			hold_reg <= '0;
			hold_valid <= 1'b0;
			status_reg <= 1'b0;
		end else begin
			if (pop) begin
				hold_reg <= head;
				hold_valid <= 1'b1;
			end
			status_reg <= ctrl_s2 & (pop ? head.ok :
				hold_valid & hold_reg.ok);
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			out_sreg <= '0;
			data_reg <= 1'b0;
		end else if (pop) begin
			out_sreg <= head_word;
		end else if (hclk_rise && !ctrl_s2) begin
			// no check on ok here; the host relies on status instead
			data_reg <= out_sreg[WORD_W-1];
			out_sreg <= {out_sreg[WORD_W-2:0], 1'b0};
		end
	end

	assign status_o = status_reg;
	assign data_o = data_reg;

	sequence s_line_start;
		state == VAB_WAIT && start;
	endsequence
	sequence s_last_bit;
		state == VAB_SHIFT && bit_cnt == LAST_BIT;
	endsequence

	a_line_start: assert property (@(posedge sub_clk_i) disable iff (lrst)
		s_line_start |=> state == VAB_SHIFT && bit_cnt == 7'h0 &&
			line_cnt == CODE_LINE_V)
		else $error("code capture did not start on the code line");
	a_shift_line: assert property (@(posedge sub_clk_i) disable iff (lrst)
		(state == VAB_WAIT) ##1 (state == VAB_SHIFT) |-> line_cnt == CODE_LINE_V)
		else $error("capture started on the wrong line");
	a_bit_count: assert property (@(posedge sub_clk_i) disable iff (lrst)
		s_last_bit |=> state == VAB_CHECK ##1 state == VAB_SEND)
		else $error("capture did not end after the last code bit");
	a_shift_stays: assert property (@(posedge sub_clk_i) disable iff (lrst)
		state == VAB_SHIFT && bit_cnt != LAST_BIT |=> state == VAB_SHIFT &&
			bit_cnt == $past(bit_cnt) + 7'h1)
		else $error("capture left early");
	a_status_drop: assert property (@(posedge clock_i) disable iff (rst_i)
		$fell(ctrl_s2) |=> !status_o)
		else $error("status did not fall after request went low");
	a_status_ok_only: assert property (@(posedge clock_i) disable iff (rst_i)
		status_o |-> hold_valid && hold_reg.ok && $past(ctrl_s2))
		else $error("status high for a failed code or without request");
	a_status_raise: assert property (@(posedge clock_i) disable iff (rst_i)
		ctrl_s2 && hold_valid && hold_reg.ok |=> status_o == hold_reg.ok)
		else $error("status missing for a good held code");
	a_shift_out: assert property (@(posedge clock_i) disable iff (rst_i)
		hclk_rise && !ctrl_s2 |=> data_o == $past(out_sreg[WORD_W-1]) &&
			out_sreg == {$past(out_sreg[WORD_W-2:0]), 1'b0})
		else $error("host clock edge did not shift one bit out");
	a_load_payload: assert property (@(posedge clock_i) disable iff (rst_i)
		pop |=> out_sreg == $past(head_word))
		else $error("output shifter not loaded with the buffered code");
	a_buffer_stall: assert property (@(posedge clock_i) disable iff (rst_i)
		new_word && full |=> ack_tgl == $past(ack_tgl) &&
			count == $past(count) - {1'b0, $past(pop)})
		else $error("full buffer accepted a word");
endmodule

// >>> vab_host_model.sv
/*
 vab_host_model: host that requests the held code and shifts it out.
 Assumes clock_i is the 200 MHz system clock of the buffer.
*/
`timescale 1ns/1ps
module vab_host_model
	import vab_pkg::*;
(
	input wire logic clock_i,
	input wire logic status_i,
	input wire logic data_i,
	output logic ctrl_o,
	output logic host_clk_o
);
	initial begin
		ctrl_o = 1'b0;
		host_clk_o = 1'b0;
	end
	// gap slows the host down; the minimum waits always apply
	task automatic read_word(output logic ok, output logic late,
		output logic [WORD_W-1:0] w, input int gap);
		int n;
		w = '0;
		@(posedge clock_i) #1 ctrl_o = 1'b1;
		for (n = 0; n < 400 && status_i !== 1'b1; n++) begin
			@(posedge clock_i);
			#1;
		end
		ok = status_i;
		repeat (STATUS_MAX_CYC + gap) @(posedge clock_i);
		#1 ctrl_o = 1'b0;
		repeat (STATUS_MAX_CYC + gap) @(posedge clock_i);
		// a full microsecond after the drop, status must be down already
		late = status_i;
		for (n = 0; n < WORD_W; n++) begin
			#1 host_clk_o = 1'b1;
			// sample late in the high phase, data settles 3 cycles in
			repeat (4) @(posedge clock_i);
			w = {w[WORD_W-2:0], data_i};
			#1 host_clk_o = 1'b0;
			repeat (4) @(posedge clock_i);
		end
	endtask
endmodule

// >>> testbench.sv
/*
 testbench: sends coded fields on the subcarrier clock and reads them
 back through the host model. Assumes vab_pkg and the host model.
*/
`timescale 1ns/1ps
module testbench;
	import vab_pkg::*;
	logic clock_i, rst_i, sub_clk_i, field_sync_i, line_sync_i;
	logic video_bit_i, ctrl_i, host_clk_i, status_o, data_o, ok, late;
	logic [WORD_W-1:0] got;
	int num_errors = 0;
	int total_checks = 0;
	localparam logic [WORD_W-1:0] W1 = {18'h2a5c3, 6'h2d, 27'h5a3c96f};

	vab_aux_code_buffer DUT (.clock_i(clock_i), .rst_i(rst_i),
		.sub_clk_i(sub_clk_i), .field_sync_i(field_sync_i),
		.line_sync_i(line_sync_i), .video_bit_i(video_bit_i),
		.ctrl_i(ctrl_i), .host_clk_i(host_clk_i), .status_o(status_o),
		.data_o(data_o));
	vab_host_model host (.clock_i(clock_i), .status_i(status_o),
		.data_i(data_o), .ctrl_o(ctrl_i), .host_clk_o(host_clk_i));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	// subcarrier runs free, phase unrelated to the system clock
	initial begin
		sub_clk_i = 1'b0;
		#7;
		forever #15 sub_clk_i = ~sub_clk_i;
	end

	task complete_run;
		if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input string name, input logic [WORD_W-1:0] exp, seen);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task chk_bit(input string name, input logic exp, seen);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %b, seen %b", name, exp, seen);
		end
	endtask

	function automatic logic [CRC_W-1:0] crc_of(logic [WORD_W-1:0] d);
		logic [CRC_W-1:0] c;
		c = CRC_INIT;
		for (int i = WORD_W - 1; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
		return c;
	endfunction

	// the first code bit is driven one edge after the line pulse, as the syncs expect
	task send_code(input logic [WORD_W-1:0] w, input logic bad);
		logic [CODE_BITS-1:0] code;
		code = {10'h2aa, w, crc_of(w) ^ {15'h0000, bad}};
		for (int i = CODE_BITS - 1; i >= 0; i--) begin
			@(posedge sub_clk_i) #1 video_bit_i = code[i];
			line_sync_i = 1'b0;
		end
		@(posedge sub_clk_i) #1 video_bit_i = 1'b0;
	endtask

	// line 16 carries a decoy code that must be ignored
	task send_field(input logic [WORD_W-1:0] w, input logic bad);
		@(posedge sub_clk_i) #1 field_sync_i = 1'b1;
		@(posedge sub_clk_i) #1 field_sync_i = 1'b0;
		for (int l = 1; l <= CODE_LINE; l++) begin
			repeat (3) @(posedge sub_clk_i);
			#1 line_sync_i = 1'b1;
			if (l >= CODE_LINE - 1)
				send_code(l == CODE_LINE ? w : ~w, bad);
			else
				@(posedge sub_clk_i) #1 line_sync_i = 1'b0;
		end
		repeat (20) @(posedge sub_clk_i);
	endtask

	task t_reset;
		chk_bit("status_o", 1'b0, status_o);
		chk_bit("data_o", 1'b0, data_o);
	endtask

	task t_good;
		send_field(W1, 1'b0);
		host.read_word(ok, late, got, 0);
		chk_bit("status", 1'b1, ok);
		chk("word", W1, got);
		chk_bit("status_late", 1'b0, late);
		chk_bit("status_o", 1'b0, status_o);
	endtask

	// a failed check still loads the shifter, only status stays low
	task t_bad;
		send_field(~W1, 1'b1);
		host.read_word(ok, late, got, 37);
		chk_bit("status", 1'b0, ok);
		chk("word", ~W1, got);
	endtask

	// third field waits at the link behind a full buffer and is not lost;
	// the read drains all three, so the newest code ends up in the shifter
	task t_fill;
		send_field(W1 ^ 51'h0f0f0f0f0f0f0, 1'b0);
		send_field(W1 ^ 51'h1234567, 1'b0);
		send_field(W1 ^ 51'h7ffffffffffff, 1'b0);
		host.read_word(ok, late, got, 0);
		chk_bit("status", 1'b1, ok);
		chk("word", W1 ^ 51'h7ffffffffffff, got);
	endtask

	initial begin
		rst_i = 1'b1;
		field_sync_i = 1'b0;
		line_sync_i = 1'b0;
		video_bit_i = 1'b0;
		repeat (8) @(posedge clock_i);
		// the link side needs one subcarrier edge inside reset
		repeat (3) @(posedge sub_clk_i);
		#1 rst_i = 1'b0;
		repeat (4) @(posedge sub_clk_i);
		t_reset;
		t_good;
		t_bad;
		t_fill;
		complete_run;
	end

	initial begin
		#200000;
		num_errors++;
		complete_run;
	end
endmodule
